// ===== logic/tmc_tach.v
// Tachometer measure and compare block with Avalon-MM register slave.
// Assumes one 100 MHz clock and a pulse input from an external sensor.
`timescale 1ns/10ps
`include "tmc_regs.vh"

// ****************************************************************
// Comparison channel: hysteresis, off-delay, polarity, ON counter
// ****************************************************************
module tmc_chan (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Measurement side
  input wire run_in,
  input wire ms_tick_in,
  input wire [19:0] meas_in,
  input wire ovf_in,
  input wire [19:0] thr_in,
  input wire [19:0] max_thr_in,
  input wire [19:0] hyst_in,
  input wire [15:0] offdly_in,
  input wire inv_in,
  // Results
  output reg act_out,
  output reg pin_out,
  output reg [15:0] kilo_out
);
  reg raw_ff;
  reg [15:0] dly_ff;
  reg [9:0] unit_ff;
  wire hit;
  wire rel;
  assign hit = ovf_in | ((thr_in <= max_thr_in) & (meas_in >= thr_in));
  assign rel = ~ovf_in & (({1'b0, meas_in} + {1'b0, hyst_in}) < {1'b0, thr_in});

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      raw_ff <= 1'b0;
      act_out <= 1'b0;
      dly_ff <= 16'h0000;
      pin_out <= 1'b0;
      unit_ff <= 10'h000;
      kilo_out <= 16'h0000;
    end else begin
      if (!run_in) begin
        raw_ff <= 1'b0;
      end else if (hit) begin
        raw_ff <= 1'b1;
      end else if (rel) begin
        raw_ff <= 1'b0;
      end
      if (raw_ff) begin
        act_out <= 1'b1;
        dly_ff <= 16'h0000;
      end else if (act_out && !run_in) begin
        act_out <= 1'b0;
      end else if (act_out && ms_tick_in) begin
        if (dly_ff >= offdly_in) begin
          act_out <= 1'b0;
        end else begin
          dly_ff <= dly_ff + 16'h0001;
        end
      end
      pin_out <= run_in & (act_out ^ inv_in);
      if (raw_ff && !act_out) begin
        if (unit_ff == `TMC_KILO) begin
          unit_ff <= 10'h000;
          kilo_out <= kilo_out + 16'h0001;
        end else begin
          unit_ff <= unit_ff + 10'h001;
        end
      end
    end
  end
endmodule // tmc_chan

// ****************************************************************
// Top level
// ****************************************************************
module tmc_tach #(
  parameter MS_DIV = `TMC_MS_NS * `TMC_CLK_MHZ / 1000
) (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Pulse sensor
  input wire pulse_in,
  // Avalon-MM slave
  input wire [5:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output wire avs_waitrequest_out,
  // Output terminals and display
  output reg term_a_out,
  output reg term_b_out,
  output reg colour_green_out,
  output reg colour_red_out
);
  localparam SUM_W = 24;
  localparam [15:0] CONT_LEN = `TMC_CONT_MS;
  localparam [15:0] SAMP_LEN = `TMC_SAMPLE_MS;
  localparam [19:0] CONT_MUL = `TMC_SECOND_MS / `TMC_CONT_MS;
  localparam [19:0] SAMP_MUL = `TMC_SECOND_MS / `TMC_SAMPLE_MS;
  // Registers
  reg [12:0] ctrl_ff;
  reg [19:0] pre_ff;
  reg [19:0] thr1_ff;
  reg [19:0] thr2_ff;
  reg [19:0] hyst_ff;
  reg [15:0] offdly_ff;
  reg [15:0] autoz_ff;
  reg [15:0] startup_ff;
  reg [19:0] clamp_ff;
  reg ack_ff;
  wire req;
  wire wr_go;
  reg [31:0] nxt_rdata;
  // Pulse input and timebase
  reg [2:0] sync_ff;
  reg lvl_ff;
  reg [16:0] div_ff;
  reg ms_ff;
  wire rise;
  wire fall;
  // Measurement
  reg [15:0] win_ms_ff;
  reg [19:0] pcnt_ff;
  reg [19:0] tmeas_ff;
  reg [15:0] idle_ms_ff;
  reg samp_ff;
  reg [19:0] sval_ff;
  reg [15:0] st_ms_ff;
  reg run_ff;
  reg cfg_clr_ff;
  wire [15:0] win_len;
  wire [19:0] win_mul;
  wire width_m;
  wire zeroed;
  // Averaging
  reg [19:0] hist_ff [0:15];
  reg [3:0] ptr_ff;
  reg [3:0] bcnt_ff;
  reg avg_go_ff;
  reg [19:0] avg_ff;
  reg avg_new_ff;
  reg [SUM_W-1:0] nxt_sum;
  wire [SUM_W-1:0] avg_sh;
  reg [4:0] navg;
  reg [2:0] nsh;
  integer i;
  // Scaled result
  reg [19:0] meas_ff;
  reg ovf_ff;
  reg [19:0] peak_ff;
  reg [19:0] bot_ff;
  wire [39:0] prod;
  wire [31:0] scaled;
  wire [19:0] max_thr;
  // Channels
  wire act1;
  wire act2;
  wire pin1;
  wire pin2;
  wire [15:0] kilo1;
  wire [15:0] kilo2;
  wire any_on;
  wire [1:0] col;

  // ****************************************************************
  // Avalon-MM slave: one wait cycle, then the request is taken
  // ****************************************************************
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_ff;
  assign wr_go = avs_write_in & ack_ff;

  always @* begin
    case (avs_address_in)
      `TMC_A_CTRL: nxt_rdata = {19'h0_0000, ctrl_ff};
      `TMC_A_PRESCALE: nxt_rdata = {12'h000, pre_ff};
      `TMC_A_THR1: nxt_rdata = {12'h000, thr1_ff};
      `TMC_A_THR2: nxt_rdata = {12'h000, thr2_ff};
      `TMC_A_HYST: nxt_rdata = {12'h000, hyst_ff};
      `TMC_A_OFFDLY: nxt_rdata = {16'h0000, offdly_ff};
      `TMC_A_AUTOZ: nxt_rdata = {16'h0000, autoz_ff};
      `TMC_A_STARTUP: nxt_rdata = {16'h0000, startup_ff};
      `TMC_A_CLAMP: nxt_rdata = {12'h000, clamp_ff};
      `TMC_A_MEAS: nxt_rdata = {12'h000, meas_ff};
      `TMC_A_PEAK: nxt_rdata = {12'h000, peak_ff};
      `TMC_A_BOTTOM: nxt_rdata = {12'h000, bot_ff};
      `TMC_A_ONK1: nxt_rdata = {16'h0000, kilo1};
      `TMC_A_ONK2: nxt_rdata = {16'h0000, kilo2};
      `TMC_A_STATUS: nxt_rdata = {27'h000_0000, colour_green_out, act2, act1, ovf_ff, run_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
      ctrl_ff <= 13'h0000;
      pre_ff <= 20'h0_0000;
      thr1_ff <= `TMC_MAX_COUNT;
      thr2_ff <= `TMC_MAX_COUNT;
      hyst_ff <= 20'h0_0000;
      offdly_ff <= 16'h0000;
      autoz_ff <= 16'h0000;
      startup_ff <= 16'h0000;
      clamp_ff <= `TMC_CLAMP_RST;
      cfg_clr_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req && !ack_ff) begin
        avs_readdata_out <= nxt_rdata;
      end
      cfg_clr_ff <= wr_go & ((avs_address_in == `TMC_A_CTRL) | (avs_address_in == `TMC_A_PRESCALE));
      if (wr_go) begin
        case (avs_address_in)
          `TMC_A_CTRL: ctrl_ff <= avs_writedata_in[12:0];
          `TMC_A_PRESCALE: pre_ff <= avs_writedata_in[19:0];
          `TMC_A_THR1: begin
            thr1_ff <= (avs_writedata_in[19:0] > clamp_ff) ? clamp_ff : avs_writedata_in[19:0];
          end
          `TMC_A_THR2: begin
            thr2_ff <= (avs_writedata_in[19:0] > clamp_ff) ? clamp_ff : avs_writedata_in[19:0];
          end
          `TMC_A_HYST: hyst_ff <= avs_writedata_in[19:0];
          `TMC_A_OFFDLY: offdly_ff <= avs_writedata_in[15:0];
          `TMC_A_AUTOZ: autoz_ff <= avs_writedata_in[15:0];
          `TMC_A_STARTUP: startup_ff <= avs_writedata_in[15:0];
          `TMC_A_CLAMP: begin
            if (avs_writedata_in[19:0] < `TMC_CLAMP_MIN) begin
              clamp_ff <= `TMC_CLAMP_MIN;
            end else if (avs_writedata_in[19:0] > `TMC_MAX_COUNT) begin
              clamp_ff <= `TMC_MAX_COUNT;
            end else begin
              clamp_ff <= avs_writedata_in[19:0];
            end
          end
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end

  // ****************************************************************
  // Pulse filter and millisecond timebase
  // ****************************************************************
  assign rise = (sync_ff[1] == sync_ff[2]) & sync_ff[2] & ~lvl_ff;
  assign fall = (sync_ff[1] == sync_ff[2]) & ~sync_ff[2] & lvl_ff;

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_ff <= 3'h0;
      lvl_ff <= 1'b0;
      div_ff <= 17'h0_0000;
      ms_ff <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[1:0], pulse_in};
      if (sync_ff[1] == sync_ff[2]) begin
        lvl_ff <= sync_ff[2];
      end
      ms_ff <= (div_ff == MS_DIV[16:0] - 17'h0_0001);
      div_ff <= (div_ff == MS_DIV[16:0] - 17'h0_0001) ? 17'h0_0000 : div_ff + 17'h0_0001;
    end
  end

  // ****************************************************************
  // Startup inhibit and raw sampling
  // ****************************************************************
  assign width_m = ctrl_ff[`TMC_C_WIDTH];
  assign win_len = ctrl_ff[`TMC_C_CONT] ? CONT_LEN : SAMP_LEN;
  assign win_mul = ctrl_ff[`TMC_C_CONT] ? CONT_MUL : SAMP_MUL;
  assign zeroed = !width_m && (autoz_ff != 16'h0000) && (idle_ms_ff >= autoz_ff);

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ms_ff <= 16'h0000;
      run_ff <= 1'b0;
      win_ms_ff <= 16'h0000;
      pcnt_ff <= 20'h0_0000;
      tmeas_ff <= 20'h0_0000;
      idle_ms_ff <= 16'h0000;
      samp_ff <= 1'b0;
      sval_ff <= 20'h0_0000;
    end else begin
      samp_ff <= 1'b0;
      if (!run_ff) begin
        if (st_ms_ff >= startup_ff) begin
          run_ff <= 1'b1;
        end else if (ms_ff) begin
          st_ms_ff <= st_ms_ff + 16'h0001;
        end
        win_ms_ff <= 16'h0000;
        pcnt_ff <= 20'h0_0000;
        idle_ms_ff <= 16'h0000;
      end else begin
        if (rise) begin
          idle_ms_ff <= 16'h0000;
        end else if (ms_ff && !zeroed) begin
          idle_ms_ff <= idle_ms_ff + 16'h0001;
        end
        if (width_m) begin
          if (rise) begin
            tmeas_ff <= 20'h0_0000;
          end else if (lvl_ff && ms_ff) begin
            tmeas_ff <= tmeas_ff + 20'h0_0001;
          end
          if (fall) begin
            samp_ff <= 1'b1;
            sval_ff <= tmeas_ff;
          end
        end else if (ctrl_ff[`TMC_C_PERIOD]) begin
          if (rise) begin
            samp_ff <= 1'b1;
            sval_ff <= tmeas_ff;
            tmeas_ff <= 20'h0_0000;
          end else if (ms_ff) begin
            tmeas_ff <= tmeas_ff + 20'h0_0001;
          end
          if (zeroed && ms_ff) begin
            samp_ff <= 1'b1;
            sval_ff <= 20'h0_0000;
          end
        end else begin
          if (cfg_clr_ff) begin
            // Restart the window so a mode change leaves no stale count
            win_ms_ff <= 16'h0000;
            pcnt_ff <= 20'h0_0000;
          end else if (ms_ff && win_ms_ff == win_len - 16'h0001) begin
            win_ms_ff <= 16'h0000;
            samp_ff <= 1'b1;
            sval_ff <= zeroed ? 20'h0_0000 : pcnt_ff * win_mul;
            pcnt_ff <= rise ? 20'h0_0001 : 20'h0_0000;
          end else begin
            if (ms_ff) begin
              win_ms_ff <= win_ms_ff + 16'h0001;
            end
            if (rise) begin
              pcnt_ff <= pcnt_ff + 20'h0_0001;
            end
          end
        end
      end
    end
  end

  // ****************************************************************
  // Averaging over the last 1, 2, 4, 8 or 16 samples
  // ****************************************************************
  always @* begin
    case (ctrl_ff[`TMC_C_AVG_HI:`TMC_C_AVG_LO])
      3'h1: begin navg = 5'h02; nsh = 3'h1; end
      3'h2: begin navg = 5'h04; nsh = 3'h2; end
      3'h3: begin navg = 5'h08; nsh = 3'h3; end
      3'h4: begin navg = 5'h10; nsh = 3'h4; end
      default: begin navg = 5'h01; nsh = 3'h0; end
    endcase
    nxt_sum = {SUM_W{1'b0}};
    for (i = 0; i < 16; i = i + 1) begin
      if (i < navg) begin
        nxt_sum = nxt_sum + {4'h0, hist_ff[ptr_ff - i[3:0] - 4'h1]};
      end
    end
  end

  assign avg_sh = nxt_sum >> nsh;

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_ff <= 4'h0;
      bcnt_ff <= 4'h0;
      avg_go_ff <= 1'b0;
      avg_ff <= 20'h0_0000;
      avg_new_ff <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        hist_ff[i] <= 20'h0_0000;
      end
    end else begin
      avg_go_ff <= 1'b0;
      avg_new_ff <= avg_go_ff;
      if (samp_ff) begin
        hist_ff[ptr_ff] <= sval_ff;
        ptr_ff <= ptr_ff + 4'h1;
        if ({1'b0, bcnt_ff} + 5'h01 >= navg || ctrl_ff[`TMC_C_MOVING]) begin
          bcnt_ff <= 4'h0;
          avg_go_ff <= 1'b1;
        end else begin
          bcnt_ff <= bcnt_ff + 4'h1;
        end
      end
      if (avg_go_ff) begin
        avg_ff <= (avg_sh > {4'h0, `TMC_MAX_COUNT}) ? `TMC_MAX_COUNT : avg_sh[19:0];
      end
    end
  end

  // ****************************************************************
  // Prescale, overflow, peak and bottom
  // ****************************************************************
  assign prod = {20'h0_0000, avg_ff} * {20'h0_0000, pre_ff};
  assign scaled = (pre_ff == 20'h0_0000) ? {12'h000, avg_ff} : prod[`TMC_PRE_FRAC+31:`TMC_PRE_FRAC];
  assign max_thr = `TMC_MAX_COUNT - {8'h00, pre_ff[19:`TMC_PRE_FRAC]};

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meas_ff <= 20'h0_0000;
      ovf_ff <= 1'b0;
      peak_ff <= 20'h0_0000;
      bot_ff <= `TMC_MAX_COUNT;
    end else begin
      if (cfg_clr_ff) begin
        peak_ff <= 20'h0_0000;
        bot_ff <= `TMC_MAX_COUNT;
        ovf_ff <= 1'b0;
      end else if (avg_new_ff) begin
        ovf_ff <= scaled > {12'h000, `TMC_MAX_COUNT};
        meas_ff <= (scaled > {12'h000, `TMC_MAX_COUNT}) ? `TMC_MAX_COUNT : scaled[19:0];
        if (scaled[19:0] > peak_ff || scaled > {12'h000, `TMC_MAX_COUNT}) begin
          peak_ff <= (scaled > {12'h000, `TMC_MAX_COUNT}) ? `TMC_MAX_COUNT : scaled[19:0];
        end
        if (scaled < {12'h000, bot_ff}) begin
          bot_ff <= scaled[19:0];
        end
      end
    end
  end

  // ****************************************************************
  // Comparison channels, terminals and colour
  // ****************************************************************
  tmc_chan u_chan1 (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_in(run_ff),
    .ms_tick_in(ms_ff),
    .meas_in(meas_ff),
    .ovf_in(ovf_ff),
    .thr_in(thr1_ff),
    .max_thr_in(max_thr),
    .hyst_in(hyst_ff),
    .offdly_in(offdly_ff),
    .inv_in(ctrl_ff[`TMC_C_INV1]),
    .act_out(act1),
    .pin_out(pin1),
    .kilo_out(kilo1)
  );

  tmc_chan u_chan2 (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_in(run_ff),
    .ms_tick_in(ms_ff),
    .meas_in(meas_ff),
    .ovf_in(ovf_ff),
    .thr_in(thr2_ff),
    .max_thr_in(max_thr),
    .hyst_in(hyst_ff),
    .offdly_in(offdly_ff),
    .inv_in(ctrl_ff[`TMC_C_INV2]),
    .act_out(act2),
    .pin_out(pin2),
    .kilo_out(kilo2)
  );

  assign any_on = ctrl_ff[`TMC_C_AREA] ? act1 : (act1 | act2);
  assign col = ctrl_ff[`TMC_C_COL_HI:`TMC_C_COL_LO];

  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      term_a_out <= 1'b0;
      term_b_out <= 1'b0;
      colour_green_out <= 1'b0;
      colour_red_out <= 1'b1;
    end else begin
      term_a_out <= ctrl_ff[`TMC_C_SWAP] ? pin2 : pin1;
      term_b_out <= ctrl_ff[`TMC_C_SWAP] ? pin1 : pin2;
      case (col)
        `TMC_COL_GREEN: colour_green_out <= 1'b1;
        `TMC_COL_RED_IDLE: colour_green_out <= any_on;
        `TMC_COL_GREEN_IDLE: colour_green_out <= ~any_on;
        default: colour_green_out <= 1'b0;
      endcase
      case (col)
        `TMC_COL_GREEN: colour_red_out <= 1'b0;
        `TMC_COL_RED_IDLE: colour_red_out <= ~any_on;
        `TMC_COL_GREEN_IDLE: colour_red_out <= any_on;
        default: colour_red_out <= 1'b1;
      endcase
    end
  end
endmodule // tmc_tach

// ===== logic/tmc_regs.vh
// Register map, field positions and timing constants of the tachometer block.
// Assumes a 100 MHz clock and a 32-bit Avalon-MM slave with byte addresses.
`ifndef TMC_REGS_VH
`define TMC_REGS_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TMC_A_CTRL 6'h00
`define TMC_A_PRESCALE 6'h04
`define TMC_A_THR1 6'h08
`define TMC_A_THR2 6'h0C
`define TMC_A_HYST 6'h10
`define TMC_A_OFFDLY 6'h14
`define TMC_A_AUTOZ 6'h18
`define TMC_A_STARTUP 6'h1C
`define TMC_A_CLAMP 6'h20
`define TMC_A_MEAS 6'h24
`define TMC_A_PEAK 6'h28
`define TMC_A_BOTTOM 6'h2C
`define TMC_A_ONK1 6'h30
`define TMC_A_ONK2 6'h34
`define TMC_A_STATUS 6'h38
// ****************************************************************
// Control fields
// ****************************************************************
`define TMC_C_WIDTH 0
`define TMC_C_PERIOD 1
`define TMC_C_MOVING 2
`define TMC_C_AVG_LO 3
`define TMC_C_AVG_HI 5
`define TMC_C_CONT 6
`define TMC_C_SWAP 7
`define TMC_C_INV1 8
`define TMC_C_INV2 9
`define TMC_C_COL_LO 10
`define TMC_C_COL_HI 11
`define TMC_C_AREA 12
`define TMC_COL_RED 2'h0
`define TMC_COL_GREEN 2'h1
`define TMC_COL_RED_IDLE 2'h2
`define TMC_COL_GREEN_IDLE 2'h3
// ****************************************************************
// Values and timing
// ****************************************************************
`define TMC_MAX_COUNT 20'hF_423F
`define TMC_CLAMP_RST 20'hF_423F
`define TMC_CLAMP_MIN 20'h0_0001
`define TMC_PRE_FRAC 8
`define TMC_KILO 10'h3E7
`define TMC_CLK_MHZ 100
`define TMC_MS_NS 1000000
`define TMC_SECOND_MS 1000
`define TMC_SAMPLE_MS 200
`define TMC_CONT_MS 10
`define TMC_GAP_MS 20
`endif

// ===== bench/tmc_checker.sv
// Port assertions for the tachometer block.
// Assumes it is bound into tmc_tach, one clock domain.
`timescale 1ns/10ps
`include "tmc_regs.vh"
module tmc_checker (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Register bus
  input wire [5:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire avs_waitrequest_out,
  // Terminals and colour
  input wire term_a_out,
  input wire term_b_out,
  input wire colour_green_out,
  input wire colour_red_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  wire req = avs_read_in | avs_write_in;
  wire rd_ok = avs_read_in & ~avs_waitrequest_out;
  reg [1:0] age_ff;
  // Cycles since reset release, saturating
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) age_ff <= 2'h0;
    else if (age_ff != 2'h3) age_ff <= age_ff + 2'h1;
  end
  property p_wait_first;
    $rose(req) |-> avs_waitrequest_out;
  endproperty
  property p_wait_one;
    req && avs_waitrequest_out ##1 req |-> !avs_waitrequest_out;
  endproperty
  property p_idle;
    !req |-> !avs_waitrequest_out;
  endproperty
  property p_rd_hold;
    !req ##1 !req |-> $stable(avs_readdata_out);
  endproperty
  property p_unmapped;
    rd_ok && avs_address_in >= 6'h3C |-> avs_readdata_out == 32'h0000_0000;
  endproperty
  property p_ctrl_hi;
    rd_ok && avs_address_in == `TMC_A_CTRL |-> avs_readdata_out[31:13] == 19'h0_0000;
  endproperty
  property p_val_max;
    rd_ok && avs_address_in inside {`TMC_A_THR1, `TMC_A_THR2, `TMC_A_MEAS, `TMC_A_PEAK}
      |-> avs_readdata_out <= 32'h000F_423F;
  endproperty
  property p_col_one;
    colour_green_out != colour_red_out;
  endproperty
  property p_start_off;
    age_ff < 2'h2 |-> !term_a_out && !term_b_out;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait on new request");
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  a_idle: assert property (p_idle) else $error("wait while idle");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved while idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ctrl_hi: assert property (p_ctrl_hi) else $error("control high bits set");
  a_val_max: assert property (p_val_max) else $error("value above max count");
  a_col_one: assert property (p_col_one) else $error("colour not one-hot");
  a_start_off: assert property (p_start_off) else $error("terminal on at startup");
  c_read: cover property (rd_ok);
  c_term: cover property ($rose(term_a_out));
  c_green: cover property ($rose(colour_green_out));
endmodule // tmc_checker

bind tmc_tach tmc_checker u_chk (
  .mclk_in(mclk_in),
  .rst_in(rst_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .term_a_out(term_a_out),
  .term_b_out(term_b_out),
  .colour_green_out(colour_green_out),
  .colour_red_out(colour_red_out)
);

// ===== bench/tmc_pulse_src.sv
// Pulse sensor model feeding the tachometer input.
// Assumes high and low times given in clock cycles; idle line low.
`timescale 1ns/10ps
module tmc_pulse_src #(
  parameter GAP_CYC = 200
) (
  // Clock
  input wire mclk_in,
  // Pulse shape
  input wire en_in,
  input wire width_in,
  input wire [15:0] hi_in,
  input wire [15:0] lo_in,
  // Sensor line
  output reg pulse_out
);
  integer n;
  initial begin
    pulse_out = 1'b0;
    forever begin
      @(posedge mclk_in);
      if (en_in) begin
        pulse_out <= 1'b1;
        repeat (hi_in) @(posedge mclk_in);
        pulse_out <= 1'b0;
        n = (width_in && lo_in < GAP_CYC) ? GAP_CYC : lo_in;
        repeat (n - 1) @(posedge mclk_in);
      end
    end
  end
endmodule // tmc_pulse_src

// ===== bench/tb_tmc_tach.sv
// Self-checking bench for the tachometer block.
// Assumes 1 ms shortened to 10 clock cycles.
`timescale 1ns/10ps
`include "tmc_regs.vh"
module tb_tmc_tach;
  reg mclk_in;
  reg rst_in;
  reg [5:0] addr;
  reg rd;
  reg wr;
  reg [31:0] wdata;
  wire [31:0] rdata;
  wire wait_rq;
  wire pulse;
  wire term_a;
  wire term_b;
  wire green;
  wire red;
  reg en;
  reg wmode;
  reg [15:0] hi;
  reg [15:0] lo;
  reg [31:0] v;
  reg [31:0] v1;
  reg [3:0] ct [0:3];
  integer n_errors;
  integer total_checks;
  integer i;
  tmc_tach #(.MS_DIV(10)) u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .pulse_in(pulse),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq), .term_a_out(term_a),
    .term_b_out(term_b), .colour_green_out(green), .colour_red_out(red));
  tmc_pulse_src u_src (.mclk_in(mclk_in), .en_in(en), .width_in(wmode), .hi_in(hi),
    .lo_in(lo), .pulse_out(pulse));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // ********
  // Tasks
  // ********
  task wt(input integer n);
    repeat (n) @(posedge mclk_in);
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task rep(input string nm, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task bus(input w, input [5:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge mclk_in);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      t = 0;
      @(posedge mclk_in);
      while (wait_rq !== 1'b0 && t < 50) begin
        t = t + 1;
        @(posedge mclk_in);
      end
      v = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (t == 50) rep("bus", 32'h0, 32'h1);
    end
  endtask
  task chk_rd(input [5:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      rep($sformatf("reg %h", a), e, v);
    end
  endtask
  task chk_pin(input [3:0] e);
    rep("pins", {28'h0, e}, {28'h0, term_a, term_b, green, red});
  endtask
  initial begin
    #600000;
    n_errors = n_errors + 1;
    tally_and_finish;
  end
  // ********
  // Tests
  // ********
  initial begin
    n_errors = 0;
    total_checks = 0;
    rst_in = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    en = 1'b0;
    wmode = 1'b0;
    hi = 16'd50;
    lo = 16'd50;
    ct[0] = 4'b1001;
    ct[1] = 4'b1010;
    ct[2] = 4'b1010;
    ct[3] = 4'b1001;
    wt(4);
    rst_in <= 1'b0;
    chk_rd(`TMC_A_CLAMP, 32'h000F_423F);
    bus(1'b1, 6'h3C, 32'h0000_1234);
    chk_rd(6'h3C, 32'h0000_0000);
    bus(1'b1, `TMC_A_CLAMP, 32'h0000_03E8);
    bus(1'b1, `TMC_A_THR1, 32'h0000_1388);
    chk_rd(`TMC_A_THR1, 32'h0000_03E8);
    bus(1'b1, `TMC_A_CLAMP, 32'h000F_423F);
    $display("test clamp done");
    en <= 1'b1;
    wt(5000);
    chk_rd(`TMC_A_MEAS, 32'h0000_0064);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0002);
    wt(5000);
    chk_rd(`TMC_A_MEAS, 32'h0000_000A);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0000);
    bus(1'b1, `TMC_A_PRESCALE, 32'h0000_0C00);
    wt(5000);
    chk_rd(`TMC_A_MEAS, 32'h0000_04B0);
    chk_rd(`TMC_A_PEAK, 32'h0000_04B0);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0008);
    wt(5000);
    chk_rd(`TMC_A_MEAS, 32'h0000_04B0);
    $display("test measure done");
    bus(1'b1, `TMC_A_HYST, 32'h0000_0064);
    bus(1'b1, `TMC_A_THR1, 32'h0000_047E);
    bus(1'b1, `TMC_A_THR2, 32'h0000_07D0);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0800);
    wt(20);
    chk_pin(4'b1010);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0880);
    wt(20);
    chk_pin(4'b0110);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0100);
    wt(20);
    chk_pin(4'b0001);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0200);
    wt(20);
    chk_pin(4'b1101);
    for (i = 0; i < 4; i = i + 1) begin
      bus(1'b1, `TMC_A_CTRL, i << 10);
      wt(20);
      chk_pin(ct[i]);
    end
    $display("test terminals done");
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0000);
    bus(1'b1, `TMC_A_THR1, 32'h0000_04E2);
    wt(20);
    chk_pin(4'b1001);
    bus(1'b1, `TMC_A_OFFDLY, 32'h0000_0005);
    bus(1'b1, `TMC_A_THR1, 32'h0000_0546);
    wt(20);
    chk_pin(4'b1001);
    wt(80);
    chk_pin(4'b0001);
    bus(1'b1, `TMC_A_THR2, 32'h0000_03E8);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0800);
    wt(20);
    chk_pin(4'b0110);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_1800);
    wt(20);
    chk_pin(4'b0101);
    $display("test hysteresis done");
    bus(1'b1, `TMC_A_OFFDLY, 32'h0000_0000);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0000);
    bus(1'b1, `TMC_A_THR1, 32'h000F_423B);
    hi <= 16'd10;
    lo <= 16'd10;
    bus(1'b1, `TMC_A_PRESCALE, 32'h000F_FFFF);
    wt(5000);
    chk_pin(4'b1101);
    chk_rd(`TMC_A_MEAS, 32'h000F_423F);
    $display("test overflow done");
    bus(1'b1, `TMC_A_PRESCALE, 32'h0000_0000);
    bus(1'b1, `TMC_A_CTRL, 32'h0000_0001);
    wmode <= 1'b1;
    hi <= 16'd35;
    lo <= 16'd250;
    wt(3000);
    bus(1'b0, `TMC_A_MEAS, 32'h0);
    v1 = v;
    rep("width", 32'h1, {31'h0, (v1 == 32'h3 || v1 == 32'h4)});
    en <= 1'b0;
    wt(3000);
    chk_rd(`TMC_A_MEAS, v1);
    $display("test width done");
    tally_and_finish;
  end
endmodule // tb_tmc_tach
